// file: pcs_pkg.sv
// Purpose: Shared constants and types of the pin control block.
// Assumes: AXI4-Lite registers with 32-bit data and 12-bit byte addresses.
// Notes: Every register offset, field position and FUNC, DIR and OUT reset value used by the logic lives here.
package pcs_pkg;

  // ---------------------------------------------------------------
  // Bus geometry and answers
  // ---------------------------------------------------------------
  localparam int PCS_ADDR_W = 12;
  localparam int PCS_DATA_W = 32;
  localparam int PCS_STRB_W = 4;
  localparam logic [1:0] PCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PCS_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [PCS_ADDR_W-1:0] PCS_ADDR_FUNC = 12'h000;
  localparam logic [PCS_ADDR_W-1:0] PCS_ADDR_DIR = 12'h004;
  localparam logic [PCS_ADDR_W-1:0] PCS_ADDR_OUT = 12'h008;
  localparam logic [PCS_ADDR_W-1:0] PCS_ADDR_STAT = 12'h00C;

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int PCS_NPINS = 3;
  localparam int PCS_FUNC_W = 4;
  localparam int PCS_FUNC_P0_LSB = 0;
  localparam int PCS_FUNC_P1_BIT = 2;
  localparam int PCS_FUNC_P2_BIT = 3;
  localparam logic [1:0] PCS_P0_GPIO = 2'h0;
  localparam logic [1:0] PCS_P0_AUDIO = 2'h1;
  localparam logic [1:0] PCS_P0_PASS = 2'h2;
  localparam logic [PCS_FUNC_W-1:0] PCS_FUNC_RST = 4'h0;
  localparam logic [PCS_NPINS-1:0] PCS_DIR_RST = 3'h7;
  localparam logic [PCS_NPINS-1:0] PCS_OUT_RST = 3'h0;
  localparam logic [PCS_NPINS-1:0] PCS_ALL_TRI = 3'h7;
  localparam int PCS_ST_GPIO_LSB = 0;
  localparam int PCS_ST_SELFTEST = 4;
  localparam int PCS_ST_CLK_INT = 5;
  localparam int PCS_ST_IRQ = 6;
  localparam int PCS_ST_POWERED = 7;

  // ---------------------------------------------------------------
  // Self-test clock select encoding and pin sampling
  // ---------------------------------------------------------------
  localparam logic PCS_CLK_PIXEL = 1'b0;
  localparam logic PCS_CLK_INTERNAL = 1'b1;
  localparam int PCS_SYNC_W = 6;
  localparam int PCS_SYNC_PD = 0;
  localparam int PCS_SYNC_STEN = 1;
  localparam int PCS_SYNC_STCS = 2;
  localparam int PCS_SYNC_GPIO = 3;
  localparam logic [PCS_SYNC_W-1:0] PCS_SYNC_RST = 6'h00;

  typedef enum logic {PCS_PWR_DOWN, PCS_PWR_ON} pcs_pwr_t;
  typedef enum logic [2:0] {PCS_REG_FUNC, PCS_REG_DIR, PCS_REG_OUT, PCS_REG_STAT,
                            PCS_REG_NONE} pcs_reg_t;

endpackage

// file: pcs_pins_if.sv
// Purpose: Carries the synchronised control and general pins to the core.
// Assumes: All signals are on aclk.
// Notes: Driven only by the pin sampler.
`timescale 1ns/10ps
interface pcs_pins_if;
  logic pd_n_s;
  logic st_en_s;
  logic st_cs_s;
  logic [2:0] gpio_in_s;
  modport sampler (output pd_n_s, output st_en_s, output st_cs_s, output gpio_in_s);
  modport core (input pd_n_s, input st_en_s, input st_cs_s, input gpio_in_s);
endinterface

// file: pcs_pin_sync.sv
// Purpose: Two-stage synchronisers for every pin that enters from outside.
// Assumes: Pins are asynchronous to aclk.
// Notes: All stages reset to zero, which reads as powered down.
`timescale 1ns/10ps
module pcs_pin_sync
  import pcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_down_n,
  input wire logic selftest_enable_pin,
  input wire logic selftest_clock_select,
  input wire logic [PCS_NPINS-1:0] general_io_i,
  pcs_pins_if.sampler pins
);

  logic [PCS_SYNC_W-1:0] raw;
  logic [PCS_SYNC_W-1:0] meta_ff;
  logic [PCS_SYNC_W-1:0] sync_ff;

  assign raw = {general_io_i, selftest_clock_select, selftest_enable_pin, power_down_n};

  // ---------------------------------------------------------------
  // Synchroniser stages
  // ---------------------------------------------------------------
  // A floating power-down pin settles low through the pad pulldown, and reset
  // leaves the chain low, so the core starts out powered down.
  for (genvar g = 0; g < PCS_SYNC_W; g++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_ff[g] <= PCS_SYNC_RST[g];
        sync_ff[g] <= PCS_SYNC_RST[g];
      end else begin
        meta_ff[g] <= raw[g];
        sync_ff[g] <= meta_ff[g];
      end
    end
  end

  assign pins.pd_n_s = sync_ff[PCS_SYNC_PD];
  assign pins.st_en_s = sync_ff[PCS_SYNC_STEN];
  assign pins.st_cs_s = sync_ff[PCS_SYNC_STCS];
  assign pins.gpio_in_s = sync_ff[PCS_SYNC_GPIO +: PCS_NPINS];

  pd_sync_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !power_down_n |-> ##2 !pins.pd_n_s)
    else $error("power-down pin not seen two cycles later");

endmodule // pcs_pin_sync

// file: pcs_top.sv
// Purpose: Power-down, self-test select and general pin mux control.
// Assumes: Pins are asynchronous; alternate-function data comes from aclk logic.
// Notes: Registers sit on an AXI4-Lite slave; the power-down pin resets them.
// Notes on behaviour
// - Power-down pin high enables and resets everything.
// - Power-down pin low keeps device powered down.
// - Powered down: outputs tri-stated, PLL off.
// - Undriven power-down pin counts as powered down.
// - Self-test enable pin selects self-test mode.
// - Clock select: zero pixel, one internal.
// - Clock select ignored outside self-test mode.
// - Outside self-test, shared pin is interrupt input.
// - After reset general pins drive low.
// - Registers route pins to audio or pass.
`timescale 1ns/10ps
module pcs_top
  import pcs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PCS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [PCS_DATA_W-1:0] s_axi_wdata,
  input wire logic [PCS_STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PCS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [PCS_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_down_n,
  input wire logic selftest_enable_pin,
  input wire logic selftest_clock_select,
  input wire logic [PCS_NPINS-1:0] general_io_i,
  output logic [PCS_NPINS-1:0] general_io_o,
  output logic [PCS_NPINS-1:0] general_io_oe_n,
  input wire logic audio_serial_out,
  input wire logic audio_word_clock_out,
  input wire logic audio_data_lane_c,
  input wire logic selftest_pass,
  output logic device_enable,
  output logic pll_enable,
  output logic selftest_mode,
  output logic selftest_clock_internal,
  output logic external_interrupt_input
);

  pcs_pins_if pins ();

  pcs_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .power_down_n(power_down_n),
    .selftest_enable_pin(selftest_enable_pin),
    .selftest_clock_select(selftest_clock_select),
    .general_io_i(general_io_i),
    .pins(pins)
  );

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic pcs_reg_t pcs_decode(input logic [PCS_ADDR_W-1:0] addr);
    pcs_reg_t kind;
    kind = PCS_REG_NONE;
    if (addr == PCS_ADDR_FUNC) kind = PCS_REG_FUNC;
    if (addr == PCS_ADDR_DIR) kind = PCS_REG_DIR;
    if (addr == PCS_ADDR_OUT) kind = PCS_REG_OUT;
    if (addr == PCS_ADDR_STAT) kind = PCS_REG_STAT;
    return kind;
  endfunction

  // ---------------------------------------------------------------
  // Internal state
  // ---------------------------------------------------------------
  logic reg_rst;
  logic [PCS_FUNC_W-1:0] func_ff;
  logic [PCS_NPINS-1:0] dir_ff;
  logic [PCS_NPINS-1:0] out_ff;
  pcs_pwr_t pwr_state_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [PCS_ADDR_W-1:0] aw_addr_ff;
  logic [PCS_DATA_W-1:0] w_data_ff;
  logic w_byte0_ff;
  logic wr_fire;
  logic wr_ok;
  pcs_reg_t wr_kind;
  logic [PCS_DATA_W-1:0] nxt_rdata;
  logic [1:0] nxt_rresp;
  logic [PCS_NPINS-1:0] nxt_io_o;
  logic [PCS_NPINS-1:0] nxt_io_oe_n;

  // Registers stay at their defaults for as long as the pin holds the device down.
  assign reg_rst = !aresetn || !pins.pd_n_s;

  // ---------------------------------------------------------------
  // Power state
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_state_ff <= PCS_PWR_DOWN;
      device_enable <= 1'b0;
      pll_enable <= 1'b0;
    end else begin
      unique case (pwr_state_ff)
        PCS_PWR_DOWN: begin
          if (pins.pd_n_s) begin
            pwr_state_ff <= PCS_PWR_ON;
            device_enable <= 1'b1;
            pll_enable <= 1'b1;
          end
        end
        PCS_PWR_ON: begin
          if (!pins.pd_n_s) begin
            pwr_state_ff <= PCS_PWR_DOWN;
            device_enable <= 1'b0;
            pll_enable <= 1'b0;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Self-test mode, clock select and interrupt routing
  // ---------------------------------------------------------------
  // The shared pin is only one wire, so while powered up exactly one of its two uses sees it.
  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      selftest_mode <= 1'b0;
      selftest_clock_internal <= PCS_CLK_PIXEL;
      external_interrupt_input <= 1'b0;
    end else begin
      selftest_mode <= pins.st_en_s;
      if (pins.st_en_s) begin
        selftest_clock_internal <= pins.st_cs_s ? PCS_CLK_INTERNAL : PCS_CLK_PIXEL;
        external_interrupt_input <= 1'b0;
      end else begin
        selftest_clock_internal <= PCS_CLK_PIXEL;
        external_interrupt_input <= pins.st_cs_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  assign wr_fire = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
  assign wr_kind = pcs_decode(aw_addr_ff);
  // Writes while powered down are refused; the registers are held in reset then.
  assign wr_ok = wr_fire && pins.pd_n_s && (wr_kind != PCS_REG_NONE) && w_byte0_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (!aw_hold_ff) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        aw_hold_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_hold_ff <= 1'b0;
      w_data_ff <= '0;
      w_byte0_ff <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_byte0_ff <= s_axi_wstrb[0];
      end else if (!w_hold_ff) begin
        s_axi_wready <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PCS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if ((wr_kind == PCS_REG_NONE) || !pins.pd_n_s) begin
        s_axi_bresp <= PCS_RESP_SLVERR;
      end else begin
        s_axi_bresp <= PCS_RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Pin function registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (reg_rst) begin
      func_ff <= PCS_FUNC_RST;
      dir_ff <= PCS_DIR_RST;
      out_ff <= PCS_OUT_RST;
    end else if (wr_ok) begin
      unique case (wr_kind)
        PCS_REG_FUNC: func_ff <= w_data_ff[PCS_FUNC_W-1:0];
        PCS_REG_DIR: dir_ff <= w_data_ff[PCS_NPINS-1:0];
        PCS_REG_OUT: out_ff <= w_data_ff[PCS_NPINS-1:0];
        PCS_REG_STAT: ;
        PCS_REG_NONE: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdata = '0;
    nxt_rresp = PCS_RESP_OKAY;
    unique case (pcs_decode(s_axi_araddr))
      PCS_REG_FUNC: nxt_rdata[PCS_FUNC_W-1:0] = func_ff;
      PCS_REG_DIR: nxt_rdata[PCS_NPINS-1:0] = dir_ff;
      PCS_REG_OUT: nxt_rdata[PCS_NPINS-1:0] = out_ff;
      PCS_REG_STAT: begin
        nxt_rdata[PCS_ST_GPIO_LSB +: PCS_NPINS] = pins.gpio_in_s;
        nxt_rdata[PCS_ST_SELFTEST] = selftest_mode;
        nxt_rdata[PCS_ST_CLK_INT] = selftest_clock_internal;
        nxt_rdata[PCS_ST_IRQ] = external_interrupt_input;
        nxt_rdata[PCS_ST_POWERED] = (pwr_state_ff == PCS_PWR_ON);
      end
      PCS_REG_NONE: nxt_rresp = PCS_RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= nxt_rdata;
      s_axi_rresp <= nxt_rresp;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin mux
  // ---------------------------------------------------------------
  // Function code three on pin 0 is unassigned and falls back to general I/O.
  always_comb begin
    nxt_io_o = '0;
    nxt_io_oe_n = PCS_ALL_TRI;
    if (pins.pd_n_s) begin
      for (int i = 0; i < PCS_NPINS; i++) begin
        nxt_io_o[i] = out_ff[i];
        nxt_io_oe_n[i] = !dir_ff[i];
      end
      unique case (func_ff[PCS_FUNC_P0_LSB +: 2])
        PCS_P0_AUDIO: begin
          nxt_io_o[0] = audio_serial_out;
          nxt_io_oe_n[0] = 1'b0;
        end
        PCS_P0_PASS: begin
          nxt_io_o[0] = selftest_pass;
          nxt_io_oe_n[0] = 1'b0;
        end
        default: ;
      endcase
      if (func_ff[PCS_FUNC_P1_BIT]) begin
        nxt_io_o[1] = audio_word_clock_out;
        nxt_io_oe_n[1] = 1'b0;
      end
      if (func_ff[PCS_FUNC_P2_BIT]) begin
        nxt_io_o[2] = audio_data_lane_c;
        nxt_io_oe_n[2] = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      general_io_o <= '0;
      general_io_oe_n <= PCS_ALL_TRI;
    end else begin
      general_io_o <= nxt_io_o;
      general_io_oe_n <= nxt_io_oe_n;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  pd_tristate_a: assert property (!pins.pd_n_s |=>
    (general_io_oe_n == PCS_ALL_TRI) && !pll_enable)
    else $error("outputs not tri-stated or PLL on while powered down");

  pd_release_a: assert property ($rose(pins.pd_n_s) |=> device_enable &&
    (func_ff == PCS_FUNC_RST) && (dir_ff == PCS_DIR_RST) && (out_ff == PCS_OUT_RST))
    else $error("release did not enable with default registers");

  pd_hold_a: assert property (!pins.pd_n_s [*2] |-> !device_enable && !selftest_mode)
    else $error("device active while held powered down");

  selftest_mode_a: assert property (pins.pd_n_s ##1 pins.pd_n_s
    |-> selftest_mode == $past(pins.st_en_s))
    else $error("self-test mode does not follow its pin");

  clk_select_a: assert property (pins.pd_n_s && pins.st_en_s |=>
    selftest_clock_internal == $past(pins.st_cs_s))
    else $error("self-test clock select wrong");

  clk_ignore_a: assert property (!pins.st_en_s |=> !selftest_clock_internal)
    else $error("clock select used outside self-test");

  irq_route_a: assert property (pins.pd_n_s && !pins.st_en_s |=>
    external_interrupt_input == $past(pins.st_cs_s))
    else $error("interrupt input not routed from shared pin");

  gpio_default_a: assert property ($rose(pins.pd_n_s) |=>
    (general_io_oe_n == ~PCS_DIR_RST) && (general_io_o == PCS_OUT_RST))
    else $error("general pins not driving low after reset");

  audio_route_a: assert property (pins.pd_n_s &&
    (func_ff[PCS_FUNC_P0_LSB +: 2] == PCS_P0_AUDIO) |=>
    !general_io_oe_n[0] && (general_io_o[0] == $past(audio_serial_out)))
    else $error("pin 0 not carrying audio serial data");

endmodule // pcs_top

// file: pcs_host_model.sv
// Purpose: Host-side model that drives the control pins and the general pins.
// Assumes: The bench sets the commanded levels by non-blocking assignment on aclk.
// Notes: A released pin falls to its pull-down level, never to the last value seen.
`timescale 1ns/10ps
module pcs_host_model
  import pcs_pkg::*;
(
  input wire logic pd_drive,
  input wire logic pd_level,
  input wire logic st_en_level,
  input wire logic st_cs_level,
  input wire logic [PCS_NPINS-1:0] io_drive,
  input wire logic [PCS_NPINS-1:0] io_level,
  input wire logic [PCS_NPINS-1:0] general_io_o,
  input wire logic [PCS_NPINS-1:0] general_io_oe_n,
  output logic power_down_n,
  output logic selftest_enable_pin,
  output logic selftest_clock_select,
  output logic [PCS_NPINS-1:0] general_io_i
);
  // ---------------------------------------------------------------
  // Pin levels
  // ---------------------------------------------------------------
  // An undriven power-down pin reads low, so the part stays off until the host acts.
  assign power_down_n = pd_drive & pd_level;
  assign selftest_enable_pin = st_en_level;
  assign selftest_clock_select = st_cs_level;
  // The device wins a general pin when it drives; otherwise the host or the pull-down.
  always_comb begin
    for (int i = 0; i < PCS_NPINS; i++) begin
      if (!general_io_oe_n[i]) begin
        general_io_i[i] = general_io_o[i];
      end else begin
        general_io_i[i] = io_drive[i] & io_level[i];
      end
    end
  end
endmodule // pcs_host_model

// file: pcs_top_bench.sv
// Purpose: Self-checking bench for the pin control block.
// Assumes: AXI4-Lite master tasks wait for every handshake; the watchdog ends a hang.
// Notes: Pin changes are given five edges to pass the synchronisers.
`timescale 1ns/10ps
module pcs_top_bench
  import pcs_pkg::*;
();
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [PCS_ADDR_W-1:0] awaddr = '0;
  logic [PCS_ADDR_W-1:0] araddr = '0;
  logic [PCS_DATA_W-1:0] wdata = '0;
  logic [PCS_STRB_W-1:0] wstrb = '0;
  logic [PCS_STRB_W-1:0] wr_strb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [PCS_DATA_W-1:0] rdata;
  logic pd_drive = 1'b0, pd_level = 1'b0, st_en = 1'b0, st_cs = 1'b0;
  logic [PCS_NPINS-1:0] io_drive = '0, io_level = '0;
  logic audio_ser = 1'b0, audio_wc = 1'b0, audio_lc = 1'b0, st_pass = 1'b0;
  logic power_down_n, st_en_pin, st_cs_pin;
  logic [PCS_NPINS-1:0] gio_i, gio_o, gio_oe_n;
  logic device_enable, pll_enable, selftest_mode, clk_int, irq;
  int n_fail = 0;
  int samples_checked = 0;

  always #25 aclk = ~aclk;

  pcs_host_model host (.pd_drive(pd_drive), .pd_level(pd_level), .st_en_level(st_en),
    .st_cs_level(st_cs), .io_drive(io_drive), .io_level(io_level), .general_io_o(gio_o),
    .general_io_oe_n(gio_oe_n), .power_down_n(power_down_n),
    .selftest_enable_pin(st_en_pin), .selftest_clock_select(st_cs_pin),
    .general_io_i(gio_i));

  pcs_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .power_down_n(power_down_n), .selftest_enable_pin(st_en_pin),
    .selftest_clock_select(st_cs_pin), .general_io_i(gio_i), .general_io_o(gio_o),
    .general_io_oe_n(gio_oe_n), .audio_serial_out(audio_ser),
    .audio_word_clock_out(audio_wc), .audio_data_lane_c(audio_lc),
    .selftest_pass(st_pass), .device_enable(device_enable), .pll_enable(pll_enable),
    .selftest_mode(selftest_mode), .selftest_clock_internal(clk_int),
    .external_interrupt_input(irq));

  // ---------------------------------------------------------------
  // Compare, bus tasks and the closing task
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_write(input logic [PCS_ADDR_W-1:0] a, input logic [31:0] d,
                           input logic [1:0] exp_resp);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= wr_strb;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    chk("write response", 32'(exp_resp), 32'(bresp));
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [PCS_ADDR_W-1:0] a, input logic [31:0] exp_d,
                          input logic [1:0] exp_resp, input string what);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    chk(what, exp_d, rdata);
    chk("read response", 32'(exp_resp), 32'(rresp));
    rready <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    report_and_stop;
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    // The power-down pin is still released here.
    chk("device_enable", 32'h0, 32'(device_enable));
    chk("pll_enable", 32'h0, 32'(pll_enable));
    chk("pins tri", 32'h7, 32'(gio_oe_n));
    axi_write(PCS_ADDR_OUT, 32'h5, PCS_RESP_SLVERR);
    axi_read(PCS_ADDR_STAT, 32'h0, PCS_RESP_OKAY, "status off");
    pd_drive <= 1'b1;
    pd_level <= 1'b1;
    @(posedge aclk);
    chk("enable held by sync", 32'h0, 32'(device_enable));
    repeat (4) @(posedge aclk);
    chk("device_enable", 32'h1, 32'(device_enable));
    chk("pll_enable", 32'h1, 32'(pll_enable));
    chk("pins driven", 32'h0, 32'(gio_oe_n));
    chk("pins low", 32'h0, 32'(gio_o));
    axi_read(PCS_ADDR_FUNC, 32'h0, PCS_RESP_OKAY, "func reset");
    axi_read(PCS_ADDR_DIR, 32'h7, PCS_RESP_OKAY, "dir reset");
    axi_read(PCS_ADDR_OUT, 32'h0, PCS_RESP_OKAY, "out reset");
    axi_write(PCS_ADDR_OUT, 32'h5, PCS_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("pin levels", 32'h5, 32'(gio_o));
    // A write that leaves byte lane 0 unselected is answered but stores nothing.
    wr_strb <= 4'hE;
    axi_write(PCS_ADDR_OUT, 32'h2, PCS_RESP_OKAY);
    axi_read(PCS_ADDR_OUT, 32'h5, PCS_RESP_OKAY, "out kept");
    wr_strb <= 4'hF;
    axi_write(PCS_ADDR_DIR, 32'h0, PCS_RESP_OKAY);
    io_drive <= 3'h7;
    io_level <= 3'h6;
    repeat (5) @(posedge aclk);
    chk("pins released", 32'h7, 32'(gio_oe_n));
    axi_read(PCS_ADDR_STAT, 32'h86, PCS_RESP_OKAY, "status inputs");
    axi_write(PCS_ADDR_STAT, 32'hFF, PCS_RESP_OKAY);
    axi_read(PCS_ADDR_STAT, 32'h86, PCS_RESP_OKAY, "status kept");
    axi_write(12'h010, 32'h1, PCS_RESP_SLVERR);
    axi_read(12'h010, 32'h0, PCS_RESP_SLVERR, "unmapped");
    for (int k = 0; k < 4; k++) begin
      st_en <= k[1];
      st_cs <= k[0];
      repeat (5) @(posedge aclk);
      chk("selftest_mode", 32'(k[1]), 32'(selftest_mode));
      chk("clock internal", 32'(k[1] & k[0]), 32'(clk_int));
      chk("interrupt", 32'(!k[1] & k[0]), 32'(irq));
    end
    st_en <= 1'b0;
    st_cs <= 1'b0;
    io_drive <= 3'h0;
    // Pin 0 is released by DIR, so only the alternate functions may drive it.
    for (int c = 0; c < 4; c++) begin
      audio_ser <= (c != 2);
      st_pass <= (c == 2);
      axi_write(PCS_ADDR_FUNC, 32'(c), PCS_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("pin0 tri", 32'((c == 1 || c == 2) ? 0 : 1), 32'(gio_oe_n[0]));
      if (c == 1 || c == 2) chk("pin0 level", 32'h1, 32'(gio_o[0]));
    end
    audio_wc <= 1'b1;
    audio_lc <= 1'b1;
    axi_write(PCS_ADDR_FUNC, 32'hC, PCS_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("pins 1-2 tri", 32'h0, 32'(gio_oe_n[2:1]));
    chk("pins 1-2 level", 32'h3, 32'(gio_o[2:1]));
    pd_level <= 1'b0;
    repeat (5) @(posedge aclk);
    chk("device_enable", 32'h0, 32'(device_enable));
    chk("pll_enable", 32'h0, 32'(pll_enable));
    chk("pins tri", 32'h7, 32'(gio_oe_n));
    pd_level <= 1'b1;
    repeat (5) @(posedge aclk);
    chk("device_enable", 32'h1, 32'(device_enable));
    axi_read(PCS_ADDR_FUNC, 32'h0, PCS_RESP_OKAY, "func after wake");
    axi_read(PCS_ADDR_DIR, 32'h7, PCS_RESP_OKAY, "dir after wake");
    report_and_stop;
  end
endmodule // pcs_top_bench
